// ---- hdl/eacr_bank.sv ----
/*
 * auxiliary control register bank for the top privilege level: two
 * fault status and one auxiliary attribute register (all reading zero)
 * and the walk attribute control register driving four attribute lanes.
 * assumes one move request per cycle from the core pipeline, same clock;
 * answer arrives registered one cycle after the request.
 */
`include "eacr_defs.svh"

module eacr_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire eacr_pkg::eacr_req_t req_i,
  input wire logic hyp_enabled_i,
  input wire logic hyp_impdef_trap_bit_i,
  input wire logic walk_top_base_i,
  output eacr_pkg::eacr_rsp_t rsp_o,
  output logic [3:0] page_hw_attribute_out_o
);

  logic [3:0] walk_attr_enable;
  logic [3:0] walk_attr_value;
  logic [3:0] next_walk_attr_enable;
  logic [3:0] next_walk_attr_value;
  eacr_pkg::eacr_rsp_t rsp;
  eacr_pkg::eacr_rsp_t next_rsp;
  eacr_pkg::eacr_sel_t sel;
  logic top_prefix;
  logic is_top;
  logic is_kernel;

  // selection from the five encoding fields
  always_comb begin
    top_prefix = (req_i.enc.op0 == `EACR_OP0_TOP) &&
                 (req_i.enc.op1 == `EACR_OP1_TOP);
    sel = eacr_pkg::EACR_SEL_NONE;
    if (top_prefix) begin
      if (req_i.enc.crn == `EACR_CRN_FAULT &&
          req_i.enc.crm == `EACR_CRM_FAULT &&
          req_i.enc.op2 == `EACR_OP2_FAULT0) begin
        sel = eacr_pkg::EACR_SEL_FAULT0;
      end else if (req_i.enc.crn == `EACR_CRN_FAULT &&
                   req_i.enc.crm == `EACR_CRM_FAULT &&
                   req_i.enc.op2 == `EACR_OP2_FAULT1) begin
        sel = eacr_pkg::EACR_SEL_FAULT1;
      end else if (req_i.enc.crn == `EACR_CRN_AUXMEM &&
                   req_i.enc.crm == `EACR_CRM_AUXMEM &&
                   req_i.enc.op2 == `EACR_OP2_AUXMEM) begin
        sel = eacr_pkg::EACR_SEL_AUXMEM;
      end else if (req_i.enc.crn == `EACR_CRN_WALK &&
                   req_i.enc.crm == `EACR_CRM_WALK &&
                   req_i.enc.op2 == `EACR_OP2_WALK) begin
        sel = eacr_pkg::EACR_SEL_WALK;
      end
    end
  end

  assign is_top = (req_i.el == `EACR_EL_TOP);
  assign is_kernel = (req_i.el == `EACR_EL_KERNEL);

  // register state and answer
  always_comb begin
    next_walk_attr_enable = walk_attr_enable;
    next_walk_attr_value = walk_attr_value;
    next_rsp = '0;
    if (req_i.valid) begin
      next_rsp.done = 1'b1;
      case (sel)
        eacr_pkg::EACR_SEL_FAULT0,
        eacr_pkg::EACR_SEL_FAULT1,
        eacr_pkg::EACR_SEL_AUXMEM: begin
          // no storage: cached copies in translation entries never
          // differ from zero, so invalidation is software's duty only
          if (!is_top) begin
            next_rsp.undefined = 1'b1;
          end
          // rdata stays zero, writes dropped
        end
        eacr_pkg::EACR_SEL_WALK: begin
          if (is_top) begin
            if (req_i.write) begin
              next_walk_attr_enable = req_i.wdata[`EACR_WALK_EN_LSB +:
                                                  `EACR_WALK_BITS];
              next_walk_attr_value = req_i.wdata[`EACR_WALK_VAL_LSB +:
                                                 `EACR_WALK_BITS];
            end else begin
              // reserved fields 63:12 and 7:4 return zero
              next_rsp.rdata[`EACR_WALK_EN_LSB +: `EACR_WALK_BITS] =
                walk_attr_enable;
              next_rsp.rdata[`EACR_WALK_VAL_LSB +: `EACR_WALK_BITS] =
                walk_attr_value;
            end
          end else if (is_kernel && hyp_enabled_i &&
                       hyp_impdef_trap_bit_i) begin
            // read and write at level one trap alike
            next_rsp.trap = 1'b1;
            next_rsp.trap_class = `EACR_TRAP_CLASS;
          end else begin
            next_rsp.undefined = 1'b1;
          end
        end
        eacr_pkg::EACR_SEL_NONE: begin
          next_rsp.done = 1'b0;
        end
        default: begin
          next_rsp.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // value bits are unknown after reset; zero chosen for determinism
      walk_attr_enable <= `EACR_WALK_EN_RESET;
      walk_attr_value <= `EACR_WALK_VAL_RESET;
      rsp <= '0;
    end else begin
      walk_attr_enable <= next_walk_attr_enable;
      walk_attr_value <= next_walk_attr_value;
      rsp <= next_rsp;
    end
  end

  assign rsp_o = rsp;

  for (genvar i = 0; i < `EACR_WALK_BITS; i++) begin : g_lane
    eacr_attr_lane u_lane (
      .enable_i(walk_attr_enable[i]),
      .value_i(walk_attr_value[i]),
      .walk_i(walk_top_base_i),
      .attr_o(page_hw_attribute_out_o[i])
    );
  end

endmodule

// ---- hdl/eacr_defs.svh ----
/*
 * constants for the top-level auxiliary control register bank:
 * system-register encodings, field positions, reset values, trap class.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef EACR_DEFS_SVH
`define EACR_DEFS_SVH

`define EACR_OP0_TOP 2'h3
`define EACR_OP1_TOP 3'h6
`define EACR_CRN_FAULT 4'h5
`define EACR_CRM_FAULT 4'h1
`define EACR_OP2_FAULT0 3'h0
`define EACR_OP2_FAULT1 3'h1
`define EACR_CRN_AUXMEM 4'hA
`define EACR_CRM_AUXMEM 4'h3
`define EACR_OP2_AUXMEM 3'h0
`define EACR_CRN_WALK 4'hF
`define EACR_CRM_WALK 4'h7
`define EACR_OP2_WALK 3'h0

`define EACR_WALK_EN_LSB 0
`define EACR_WALK_VAL_LSB 8
`define EACR_WALK_BITS 4
`define EACR_WALK_EN_RESET 4'h0
`define EACR_WALK_VAL_RESET 4'h0

`define EACR_TRAP_CLASS 6'h18
`define EACR_EL_TOP 2'h3
`define EACR_EL_HYP 2'h2
`define EACR_EL_KERNEL 2'h1

`endif

// ---- hdl/eacr_pkg.sv ----
/*
 * types for the top-level auxiliary control register bank.
 * assumes eacr_defs.svh on the include path.
 */
`include "eacr_defs.svh"

package eacr_pkg;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } eacr_sysreg_enc_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] el;
    eacr_sysreg_enc_t enc;
    logic [63:0] wdata;
  } eacr_req_t;

  typedef struct packed {
    logic done;
    logic undefined;
    logic trap;
    logic [5:0] trap_class;
    logic [63:0] rdata;
  } eacr_rsp_t;

  typedef enum logic [4:0] {
    EACR_SEL_NONE   = 5'h01,
    EACR_SEL_FAULT0 = 5'h02,
    EACR_SEL_FAULT1 = 5'h04,
    EACR_SEL_AUXMEM = 5'h08,
    EACR_SEL_WALK   = 5'h10
  } eacr_sel_t;

endpackage

// ---- hdl/eacr_attr_lane.sv ----
/*
 * one page hardware attribute output lane: value gated by its enable.
 * assumes walk_i is a same-clock qualifier from the table walker.
 */
module eacr_attr_lane (
  input wire logic enable_i,
  input wire logic value_i,
  input wire logic walk_i,
  output logic attr_o
);

  // a clear enable forces zero whatever the value bit holds
  assign attr_o = walk_i & enable_i & value_i;

endmodule

// ---- dv/eacr_bank_chk.sv ----
/* port checker for eacr_bank.
   assumes one clock and the sync reset; bound after endmodule. */
module eacr_bank_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire eacr_pkg::eacr_req_t req_i,
  input wire logic hyp_enabled_i,
  input wire logic hyp_impdef_trap_bit_i,
  input wire logic walk_top_base_i,
  input wire eacr_pkg::eacr_rsp_t rsp_o,
  input wire logic [3:0] page_hw_attribute_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic walk, rsv, el3;
  logic [3:0] wen, wval;
  // packed op0/op1/crn/crm/op2 of the four registers
  assign walk = req_i.valid && req_i.enc == 16'hF7B8;
  assign rsv = req_i.valid && req_i.enc inside {16'hF288, 16'hF289, 16'hF518};
  assign el3 = req_i.el == 2'h3;
  assign wen = req_i.wdata[3:0];
  assign wval = req_i.wdata[11:8];
  sequence s_walk_wr; walk && el3 && req_i.write; endsequence
  sequence s_trap_req;
    walk && req_i.el == 2'h1 && hyp_enabled_i && hyp_impdef_trap_bit_i;
  endsequence
  AST_RSV_ZERO: assert property (rsv && el3 |=> rsp_o.done && rsp_o.rdata == 0)
    else $error("reserved read not zero");
  AST_LOW_UNDEF: assert property (rsv && !el3 |=> rsp_o.undefined && rsp_o.rdata == 0)
    else $error("low level not refused");
  AST_TRAP: assert property (s_trap_req |=> rsp_o.trap && rsp_o.trap_class == 6'h18)
    else $error("trap missing");
  AST_WALK_UNDEF: assert property (walk && req_i.el == 2'h2 |=>
    rsp_o.undefined && !rsp_o.trap && rsp_o.rdata == 64'h0)
    else $error("walk access at level two not refused");
  AST_WALK_OK: assert property (s_walk_wr |=> rsp_o.done && !rsp_o.undefined)
    else $error("walk write refused");
  AST_NO_MATCH: assert property (req_i.valid && !walk && !rsv |=> !rsp_o.done)
    else $error("foreign encoding answered");
  AST_ATTR: assert property (s_walk_wr ##1 walk_top_base_i |->
    page_hw_attribute_out_o == ($past(wval) & $past(wen)))
    else $error("attribute lanes wrong");
  AST_NO_WALK: assert property (!walk_top_base_i |-> page_hw_attribute_out_o == 0)
    else $error("lanes active outside walk");
  AST_RSV_BITS: assert property (walk && el3 |=> rsp_o.rdata[63:12] == 0)
    else $error("reserved walk bits set");
endmodule

bind eacr_bank eacr_bank_chk i_eacr_bank_chk (.clk_i(clk_i), .rst_i(rst_i),
  .req_i(req_i), .hyp_enabled_i(hyp_enabled_i),
  .hyp_impdef_trap_bit_i(hyp_impdef_trap_bit_i),
  .walk_top_base_i(walk_top_base_i), .rsp_o(rsp_o),
  .page_hw_attribute_out_o(page_hw_attribute_out_o));

// ---- dv/eacr_bank_tb_top.sv ----
/* directed bench for eacr_bank.
   assumes an answer one cycle after the taken request. */
module eacr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] WALK = 16'hF7B8;
  logic clk_i = 0, rst_i = 1, hyp = 0, tbit = 0, wtb = 0;
  logic [15:0] rsv [3] = '{16'hF288, 16'hF289, 16'hF518};
  eacr_pkg::eacr_req_t req = '0;
  eacr_pkg::eacr_rsp_t rsp;
  logic [3:0] attr;
  int fails = 0, check_count = 0, cyc = 0;
  always #4 clk_i = ~clk_i;
  eacr_bank i_eacr_bank (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .hyp_enabled_i(hyp), .hyp_impdef_trap_bit_i(tbit),
    .walk_top_base_i(wtb), .rsp_o(rsp), .page_hw_attribute_out_o(attr));
  task chk(string n, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(logic w, logic [1:0] el, logic [15:0] enc, logic [63:0] d);
    @(posedge clk_i);
    req <= {1'b1, w, el, enc, d};
    @(posedge clk_i);
    req.valid <= 1'b0;
    #1;
  endtask
  task t_reserved;
    for (int el = 0; el < 4; el++) begin
      foreach (rsv[i]) begin
        acc(1'b1, 2'(el), rsv[i], '1);
        acc(1'b0, 2'(el), rsv[i], '0);
        chk("rsv data", 0, rsp.rdata);
        chk("rsv undef", el != 3, rsp.undefined);
      end
    end
  endtask
  task t_walk;
    acc(1'b0, 2'h3, WALK, 0);
    chk("reset", 0, rsp.rdata);
    acc(1'b1, 2'h3, WALK, '1);
    acc(1'b0, 2'h3, WALK, 0);
    chk("walk rd", 64'hF0F, rsp.rdata);
    @(posedge clk_i);
    wtb <= 1'b1;
    acc(1'b1, 2'h3, WALK, 64'hA0C);
    chk("attr", 4'h8, attr);
    @(posedge clk_i);
    wtb <= 1'b0;
    @(posedge clk_i);
    chk("idle", 0, attr);
  endtask
  task t_trap;
    @(posedge clk_i);
    hyp <= 1'b1;
    tbit <= 1'b1;
    acc(1'b1, 2'h1, WALK, 64'h1);
    chk("trap", 1, rsp.trap);
    chk("class", 6'h18, rsp.trap_class);
    @(posedge clk_i);
    tbit <= 1'b0;
    acc(1'b1, 2'h1, WALK, 64'h1);
    chk("undef", 1, rsp.undefined);
    @(posedge clk_i);
    hyp <= 1'b0;
    tbit <= 1'b1;
    acc(1'b1, 2'h1, WALK, 64'h1);
    chk("nohyp trap", 0, rsp.trap);
    chk("nohyp undef", 1, rsp.undefined);
    acc(1'b1, 2'h2, WALK, 64'h1);
    chk("el2 undef", 1, rsp.undefined);
    acc(1'b0, 2'h3, WALK, 0);
    chk("kept", 64'hA0C, rsp.rdata);
    acc(1'b0, 2'h3, 16'hF7B9, 0);
    chk("foreign", 0, rsp.done);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the roughly ninety cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      finish_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reserved;
    t_walk;
    t_trap;
    finish_test;
  end
endmodule
